// *** core/ctf_pkg.sv ***
package ctf_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam longint NAV_PERIOD_NS = 64'd1_000_000_000;
  localparam int NAV_PERIOD_CYCLES = int'(NAV_PERIOD_NS / CLK_PERIOD_NS);
  localparam int WC_W = 6;
  localparam logic [WC_W-1:0] WC_DEFAULT = 6'h0c;
  localparam logic [WC_W-1:0] WC_MIN = 6'h02;
  localparam logic [WC_W-1:0] AVG_DEFAULT = 6'h01;
  localparam logic [WC_W-1:0] AVG_MAX = 6'h32;
  localparam logic [4:0] CMD_MAX_LEN = 5'h1e;
  localparam logic [7:0] NAV_LAST_IDX = 8'h06;
  localparam logic [7:0] TRAIL_LAST_IDX = 8'h02;
  localparam logic [7:0] TERM_LAST_IDX = 8'h01;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_ALPHA = 8'h37;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WORDS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_AVG = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CMD_ID = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CMD_ARG = 8'h14;
  localparam int CTRL_SER_EN = 0;
  localparam int CTRL_PAR_EN = 1;
  localparam int CTRL_NAVP_EN = 2;
  localparam int CTRL_NAVS_EN = 3;
  localparam logic [3:0] CTRL_DEFAULT = 4'h3;
  localparam int NAV_NEW_BIT = 0;
  localparam int NAV_WEST_BIT = 6;
  localparam int NAV_SOUTH_BIT = 7;

  typedef enum logic [2:0] {
    CTF_IDLE = 3'b000,
    CTF_DATA = 3'b001,
    CTF_TRAIL = 3'b011,
    CTF_TERM = 3'b010,
    CTF_NAVP = 3'b110,
    CTF_NAVS = 3'b111,
    CTF_NAVT = 3'b101
  } ctf_phase_e;

  typedef struct packed {
    logic [23:0] lat;
    logic [23:0] lon;
    logic south;
    logic west;
  } ctf_nav_s;

  typedef struct packed {
    logic [11:0] pt;
    logic [3:0] status;
  } ctf_trail_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } ctf_reg_req_s;

  typedef struct packed {
    ctf_phase_e phase;
    logic [7:0] idx;
    logic have;
    logic raw;
    logic nib;
    logic need_ser;
    logic need_par;
    logic eoi;
    logic [7:0] cur;
    logic [7:0] seq;
    ctf_trail_s trail;
    ctf_nav_s nav;
    logic nav_new;
    logic nav_pend;
    logic [55:0] nav_snap;
    logic [31:0] sec_cnt;
    logic [3:0] ctrl;
    logic [WC_W-1:0] wc;
    logic [WC_W-1:0] avg;
    logic boot;
    logic [4:0] rx_len;
    logic rx_drop;
    logic rx_has_id;
    logic rx_bad;
    logic rx_cr;
    logic [7:0] rx_id;
    logic [31:0] rx_arg;
    logic cmd_valid;
    logic [7:0] cmd_id;
    logic [31:0] cmd_arg;
    logic [31:0] rdata;
  } ctf_state_s;
endpackage : ctf_pkg

// *** core/ctf_formatter.sv ***
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module ctf_formatter #(
  parameter int SEC_CYCLES = ctf_pkg::NAV_PERIOD_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire ctf_pkg::ctf_reg_req_s reg_req_in,
  output logic [31:0] reg_rdata_out,
  input wire logic panel_reset_in,
  input wire logic [ctf_pkg::WC_W-1:0] nv_avg_in,
  input wire logic scan_valid_in,
  input wire logic [7:0] scan_byte_in,
  input wire ctf_pkg::ctf_trail_s scan_trail_in,
  output logic scan_ready_out,
  input wire logic nav_strobe_in,
  input wire ctf_pkg::ctf_nav_s nav_in,
  output logic ser_valid_out,
  output logic [7:0] ser_char_out,
  input wire logic ser_ready_in,
  output logic par_valid_out,
  output logic [7:0] par_byte_out,
  output logic par_eoi_out,
  input wire logic par_ready_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_char_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_id_out,
  output logic [31:0] cmd_arg_out
);
  import ctf_pkg::*;

  ctf_state_s s;
  ctf_state_s next_s;
  logic ser_fire;
  logic par_fire;
  logic byte_done;
  logic ser_en;
  logic par_en;
  logic [7:0] last_data;
  logic [7:0] nav_byte;
  logic [55:0] nav_live;
  logic rx_digit;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_ALPHA + {4'h0, n};
  endfunction : hex_char

  function automatic logic [WC_W-1:0] clamp_avg(input logic [WC_W-1:0] v);
    if (v == '0) begin
      return AVG_DEFAULT;
    end
    return (v > AVG_MAX) ? AVG_MAX : v;
  endfunction : clamp_avg

  assign ser_en = s.ctrl[CTRL_SER_EN];
  assign par_en = s.ctrl[CTRL_PAR_EN];
  assign ser_valid_out = s.have && s.need_ser;
  assign par_valid_out = s.have && s.need_par;
  assign ser_fire = ser_valid_out && ser_ready_in;
  assign par_fire = par_valid_out && par_ready_in;
  assign byte_done = s.have && !s.need_ser && !s.need_par;
  // serial char: raw terminators or one hex digit of the held byte
  assign ser_char_out = s.raw ? s.cur :
    hex_char(s.nib ? s.cur[3:0] : s.cur[7:4]);
  assign par_byte_out = s.cur;
  assign par_eoi_out = s.have && s.need_par && s.eoi;
  assign scan_ready_out = (s.phase == CTF_DATA) && !s.have;
  assign reg_rdata_out = s.rdata;
  assign cmd_valid_out = s.cmd_valid;
  assign cmd_id_out = s.cmd_id;
  assign cmd_arg_out = s.cmd_arg;
  // active words minus the trailer word, three bytes each
  assign last_data = 8'(({2'b00, s.wc} - 8'h01) * 8'h03 - 8'h01);
  assign nav_live = {s.nav.lat, s.nav.lon, s.nav.south, s.nav.west,
    5'h00, s.nav_new};
  assign nav_byte = s.nav_snap[8'(8'h37 - {s.idx[4:0], 3'b000}) -: 8];
  assign rx_digit = (rx_char_in >= CH_ZERO) && (rx_char_in <= CH_NINE);

  always_comb begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    if (s.boot) begin
      next_s.avg = clamp_avg(nv_avg_in);
      next_s.boot = 1'b0;
    end
    // register bus
    if (reg_req_in.we) begin
      case (reg_req_in.addr)
        REG_CTRL: next_s.ctrl = reg_req_in.wdata[3:0];
        REG_WORDS: begin
          next_s.wc = (reg_req_in.wdata[WC_W-1:0] < WC_MIN) ? WC_MIN :
            reg_req_in.wdata[WC_W-1:0];
        end
        REG_AVG: next_s.avg = clamp_avg(reg_req_in.wdata[WC_W-1:0]);
        default: begin
        end
      endcase
    end
    if (reg_req_in.re) begin
      case (reg_req_in.addr)
        REG_CTRL: next_s.rdata = {28'h000_0000, s.ctrl};
        REG_WORDS: next_s.rdata = {26'h000_0000, s.wc};
        REG_AVG: next_s.rdata = {26'h000_0000, s.avg};
        REG_STATUS: begin
          next_s.rdata = {20'h0_0000, s.nav_pend, s.phase, s.seq};
        end
        REG_CMD_ID: next_s.rdata = {24'h00_0000, s.cmd_id};
        REG_CMD_ARG: next_s.rdata = s.cmd_arg;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (panel_reset_in) begin
      next_s.ctrl = CTRL_DEFAULT;
      next_s.wc = WC_DEFAULT;
    end
    // navigation capture and once-per-second request
    if (nav_strobe_in) begin
      next_s.nav = nav_in;
    end
    if (s.sec_cnt == 32'(SEC_CYCLES - 1)) begin
      next_s.sec_cnt = 32'h0000_0000;
    end else begin
      next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
    end
    // output handshakes
    if (ser_fire) begin
      if (s.raw || s.nib) begin
        next_s.need_ser = 1'b0;
      end else begin
        next_s.nib = 1'b1;
      end
    end
    if (par_fire) begin
      next_s.need_par = 1'b0;
    end
    if (byte_done) begin
      next_s.have = 1'b0;
      next_s.idx = s.idx + 8'h01;
      case (s.phase)
        CTF_DATA: begin
          if (s.idx == last_data) begin
            next_s.phase = CTF_TRAIL;
            next_s.idx = 8'h00;
          end
        end
        CTF_TRAIL: begin
          if (s.idx == TRAIL_LAST_IDX) begin
            next_s.seq = s.seq + {2'b00, s.avg};
            next_s.phase = CTF_TERM;
            next_s.idx = 8'h00;
          end
        end
        CTF_TERM: begin
          if (s.idx == TERM_LAST_IDX) begin
            next_s.phase = CTF_NAVP;
            next_s.idx = 8'h00;
          end
        end
        CTF_NAVP: begin
          if (s.idx == NAV_LAST_IDX) begin
            next_s.phase = CTF_IDLE;
          end
        end
        CTF_NAVS: begin
          if (s.idx == NAV_LAST_IDX) begin
            next_s.phase = CTF_NAVT;
            next_s.idx = 8'h00;
          end
        end
        CTF_NAVT: begin
          if (s.idx == TERM_LAST_IDX) begin
            next_s.phase = CTF_IDLE;
          end
        end
        default: next_s.phase = CTF_IDLE;
      endcase
    end else if (!s.have) begin
      next_s.raw = 1'b0;
      next_s.nib = 1'b0;
      next_s.eoi = 1'b0;
      next_s.need_ser = ser_en;
      next_s.need_par = par_en;
      case (s.phase)
        CTF_IDLE: begin
          next_s.idx = 8'h00;
          // a nav line only starts between scan lines
          if (s.nav_pend && ser_en) begin
            next_s.phase = CTF_NAVS;
            next_s.nav_pend = 1'b0;
          end else if (scan_valid_in && (ser_en || par_en)) begin
            next_s.phase = CTF_DATA;
            next_s.trail = scan_trail_in;
          end
        end
        CTF_DATA: begin
          if (scan_valid_in) begin
            next_s.cur = scan_byte_in;
            next_s.have = 1'b1;
          end
        end
        CTF_TRAIL: begin
          next_s.have = 1'b1;
          case (s.idx[1:0])
            2'b00: next_s.cur = s.trail.pt[11:4];
            2'b01: begin
              next_s.cur = {s.trail.pt[3:0], s.trail.status};
            end
            default: begin
              next_s.cur = s.seq;
              next_s.eoi = 1'b1;
            end
          endcase
        end
        CTF_TERM, CTF_NAVT: begin
          next_s.need_par = 1'b0;
          if (ser_en) begin
            next_s.have = 1'b1;
            next_s.raw = 1'b1;
            next_s.cur = (s.idx == 8'h00) ? CH_CR : CH_LF;
          end else begin
            next_s.phase = (s.phase == CTF_TERM) ? CTF_NAVP : CTF_IDLE;
            next_s.idx = 8'h00;
          end
        end
        CTF_NAVP: begin
          next_s.need_ser = 1'b0;
          if (par_en && s.ctrl[CTRL_NAVP_EN]) begin
            next_s.have = 1'b1;
            next_s.cur = nav_byte;
          end else begin
            next_s.phase = CTF_IDLE;
          end
        end
        CTF_NAVS: begin
          next_s.need_par = 1'b0;
          next_s.have = 1'b1;
          next_s.cur = nav_byte;
        end
        default: next_s.phase = CTF_IDLE;
      endcase
    end
    // freeze a nav record only when a nav block is really sent
    if (next_s.phase != s.phase && (next_s.phase == CTF_NAVS ||
        (next_s.phase == CTF_NAVP && par_en && s.ctrl[CTRL_NAVP_EN]))) begin
      next_s.nav_snap = nav_live;
      next_s.nav_new = 1'b0;
    end
    if (nav_strobe_in) begin
      next_s.nav_new = 1'b1;
    end
    // set wins over the clear taken when a nav line starts
    if (s.sec_cnt == 32'(SEC_CYCLES - 1) && s.ctrl[CTRL_NAVS_EN] &&
        ser_en) begin
      next_s.nav_pend = 1'b1;
    end
    // command line receiver
    if (rx_valid_in) begin
      if (rx_char_in == CH_LF) begin
        if (!s.rx_drop && s.rx_has_id && !s.rx_bad) begin
          next_s.cmd_valid = 1'b1;
          next_s.cmd_id = s.rx_id;
          next_s.cmd_arg = s.rx_arg;
        end
        next_s.rx_len = 5'h00;
        next_s.rx_drop = 1'b0;
        next_s.rx_has_id = 1'b0;
        next_s.rx_bad = 1'b0;
        next_s.rx_cr = 1'b0;
        next_s.rx_arg = 32'h0000_0000;
      end else if (!s.rx_drop) begin
        next_s.rx_len = s.rx_len + 5'h01;
        if (s.rx_len == CMD_MAX_LEN - 5'h02) begin
          next_s.rx_drop = 1'b1;
        end
        if (rx_char_in == CH_CR) begin
          next_s.rx_cr = 1'b1;
        end else if (s.rx_cr) begin
          next_s.rx_bad = 1'b1;
        end else if (!s.rx_has_id) begin
          next_s.rx_has_id = 1'b1;
          next_s.rx_id = rx_char_in;
        end else if (rx_digit) begin
          next_s.rx_arg = 32'(s.rx_arg * 32'd10) +
            {24'h00_0000, rx_char_in - CH_ZERO};
        end else begin
          next_s.rx_bad = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
      s.phase <= CTF_IDLE;
      s.ctrl <= CTRL_DEFAULT;
      s.wc <= WC_DEFAULT;
      s.avg <= AVG_DEFAULT;
      s.boot <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // helper: characters of the current serial scan line
  logic [8:0] line_cnt;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line_cnt <= 9'h000;
    end else if (s.phase == CTF_IDLE) begin
      line_cnt <= 9'h000;
    end else if (ser_fire && s.phase != CTF_NAVS && s.phase != CTF_NAVT) begin
      line_cnt <= line_cnt + 9'h001;
    end
  end

  sequence s_hi_sent;
    ser_fire && !s.raw && !s.nib;
  endsequence

  sequence s_lo_pending;
    ser_valid_out && s.nib && !s.raw && $stable(s.cur);
  endsequence

  property p_hex_pair;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_hi_sent |=> s_lo_pending;
  endproperty
  a_hex_pair: assert property (p_hex_pair)
    else $error("low nibble did not follow high nibble");

  property p_hex_case;
    @(posedge clk_in) disable iff (!arst_n_in)
      ser_valid_out && !s.raw && s.nib && s.cur[3:0] == 4'ha |->
        ser_char_out == 8'h41;
  endproperty
  a_hex_case: assert property (p_hex_case)
    else $error("hex letter not upper case");

  sequence s_cr_sent;
    ser_fire && s.phase == CTF_TERM && ser_char_out == CH_CR;
  endsequence

  property p_crlf;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_cr_sent |=> ##[0:2] (ser_valid_out && ser_char_out == CH_LF);
  endproperty
  a_crlf: assert property (p_crlf)
    else $error("line feed did not follow carriage return");

  property p_line_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      ser_fire && s.phase == CTF_TERM && ser_char_out == CH_LF |->
        line_cnt == 9'({3'b000, s.wc} * 9'd6 + 9'd1);
  endproperty
  a_line_len: assert property (p_line_len)
    else $error("serial scan line length wrong");

  property p_eoi;
    @(posedge clk_in) disable iff (!arst_n_in)
      par_eoi_out |-> s.phase == CTF_TRAIL && s.idx == TRAIL_LAST_IDX &&
        par_byte_out == s.seq;
  endproperty
  a_eoi: assert property (p_eoi)
    else $error("end marker not on modulo byte");

  property p_seq_step;
    @(posedge clk_in) disable iff (!arst_n_in)
      byte_done && s.phase == CTF_TRAIL && s.idx == TRAIL_LAST_IDX |=>
        s.seq == 8'($past(s.seq) + {2'b00, $past(s.avg)});
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence counter step wrong");

  property p_status_nibble;
    @(posedge clk_in) disable iff (!arst_n_in)
      par_valid_out && s.phase == CTF_TRAIL && s.idx == 8'h01 |->
        par_byte_out == {s.trail.pt[3:0], s.trail.status};
  endproperty
  a_status_nibble: assert property (p_status_nibble)
    else $error("status nibble misplaced");

  property p_nav_only_idle;
    @(posedge clk_in) disable iff (!arst_n_in)
      s.phase == CTF_NAVS && $past(s.phase) != CTF_NAVS |->
        $past(s.phase) == CTF_IDLE;
  endproperty
  a_nav_only_idle: assert property (p_nav_only_idle)
    else $error("nav line entered inside a scan line");

  property p_nav_flags;
    @(posedge clk_in) disable iff (!arst_n_in)
      par_valid_out && s.phase == CTF_NAVP && s.idx == NAV_LAST_IDX |->
        par_byte_out[5:1] == 5'h00;
  endproperty
  a_nav_flags: assert property (p_nav_flags)
    else $error("nav flag byte has stray bits");

  property p_drop;
    @(posedge clk_in) disable iff (!arst_n_in)
      rx_valid_in && rx_char_in == CH_LF && s.rx_drop |=> !cmd_valid_out;
  endproperty
  a_drop: assert property (p_drop)
    else $error("over-long command was accepted");

  property p_cmd_take;
    @(posedge clk_in) disable iff (!arst_n_in)
      rx_valid_in && rx_char_in == CH_LF && !s.rx_drop && s.rx_has_id &&
        !s.rx_bad |=> cmd_valid_out && cmd_id_out == $past(s.rx_id);
  endproperty
  a_cmd_take: assert property (p_cmd_take)
    else $error("valid command line not accepted");
endmodule : ctf_formatter

// *** bench/ctf_host_model.sv ***
`timescale 1ns/1ps
module ctf_host_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic slow_in,
  output logic ser_ready_out,
  output logic par_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_char_out
);
  logic [2:0] pace;

  // slow mode takes one unit in five on each port
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pace <= 3'h0;
    end else begin
      pace <= (pace == 3'h4) ? 3'h0 : pace + 3'h1;
    end
  end
  assign ser_ready_out = !slow_in || (pace == 3'h0);
  assign par_ready_out = !slow_in || (pace == 3'h2);

  initial begin
    rx_valid_out = 1'b0;
    rx_char_out = 8'h00;
  end

  // ascii line: id char, decimal digits, line feed last
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_char_out <= s[i];
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_char_out <= ~s[i];
    end
  endtask : send_line
endmodule : ctf_host_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import ctf_pkg::*;
  logic clk_in, arst_n_in, panel_reset_in, scan_valid_in, nav_strobe_in, slow;
  logic [WC_W-1:0] nv_avg_in;
  logic [7:0] scan_byte_in, ser_char_out, par_byte_out, rx_char_in, cmd_id_out;
  ctf_reg_req_s reg_req_in;
  ctf_trail_s scan_trail_in;
  ctf_nav_s nav_in;
  logic [31:0] reg_rdata_out, cmd_arg_out, rnd, rd;
  logic scan_ready_out, ser_valid_out, ser_ready_in, par_valid_out;
  logic par_eoi_out, par_ready_in, rx_valid_in, cmd_valid_out;
  int mismatches, checked, cmd_n;
  logic [7:0] seq, avg, src_q[$], ser_q[$], exp_s[$], nav_b[7];
  logic [8:0] par_q[$], exp_p[$];

  ctf_formatter #(.SEC_CYCLES(200)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .panel_reset_in(panel_reset_in),
    .nv_avg_in(nv_avg_in), .scan_valid_in(scan_valid_in),
    .scan_byte_in(scan_byte_in), .scan_trail_in(scan_trail_in),
    .scan_ready_out(scan_ready_out), .nav_strobe_in(nav_strobe_in),
    .nav_in(nav_in), .ser_valid_out(ser_valid_out),
    .ser_char_out(ser_char_out), .ser_ready_in(ser_ready_in),
    .par_valid_out(par_valid_out), .par_byte_out(par_byte_out),
    .par_eoi_out(par_eoi_out), .par_ready_in(par_ready_in),
    .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in),
    .cmd_valid_out(cmd_valid_out), .cmd_id_out(cmd_id_out),
    .cmd_arg_out(cmd_arg_out));

  ctf_host_model host (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .slow_in(slow),
    .ser_ready_out(ser_ready_in), .par_ready_out(par_ready_in),
    .rx_valid_out(rx_valid_in), .rx_char_out(rx_char_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hexc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_req_in.we <= 1'b1;
    reg_req_in.addr <= a;
    reg_req_in.wdata <= d;
    @(posedge clk_in);
    reg_req_in.we <= 1'b0;
    @(posedge clk_in);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    reg_req_in.re <= 1'b1;
    reg_req_in.addr <= a;
    @(posedge clk_in);
    reg_req_in.re <= 1'b0;
    @(posedge clk_in);
    rd = reg_rdata_out;
  endtask : reg_rd

  // wait for all expected units, then compare both streams
  task automatic drain;
    int k;
    k = 0;
    while ((ser_q.size() < exp_s.size() || par_q.size() < exp_p.size())
           && k < 20000) begin
      @(posedge clk_in);
      k++;
    end
    repeat (20) @(posedge clk_in);
    if (k == 20000) begin
      mismatches++;
      test_done();
    end
    check(32'(ser_q.size()), 32'(exp_s.size()));  // line length
    for (int i = 0; i < exp_s.size(); i++) begin
      check({24'h0, ser_q[i]}, {24'h0, exp_s[i]});  // chars
    end
    check(32'(par_q.size()), 32'(exp_p.size()));  // bus bytes
    for (int i = 0; i < exp_p.size(); i++) begin
      check({23'h0, par_q[i]}, {23'h0, exp_p[i]});  // bytes
    end
    ser_q.delete();
    par_q.delete();
    exp_s.delete();
    exp_p.delete();
  endtask : drain

  task automatic put(input logic [7:0] b, input logic [3:0] c,
                     input logic eoi);
    if (c[0]) begin
      exp_s.push_back(hexc(b[7:4]));
      exp_s.push_back(hexc(b[3:0]));
    end
    if (c[1]) exp_p.push_back({eoi, b});
  endtask : put

  task automatic scan(input int nw, input logic [3:0] c);
    logic [15:0] tr;
    rnd = lfsr(rnd);
    tr = rnd[15:0];
    scan_trail_in <= tr;
    for (int i = 0; i < (nw - 1) * 3; i++) begin
      rnd = lfsr(rnd);
      src_q.push_back(rnd[7:0]);
      put(rnd[7:0], c, 1'b0);  // unchanged data
    end
    put(tr[15:8], c, 1'b0);  // temp high
    put(tr[7:0], c, 1'b0);  // temp low and status
    put(seq, c, 1'b1);  // count with end mark
    if (c[0]) begin
      exp_s.push_back(CH_CR);
      exp_s.push_back(CH_LF);
    end
    if (c[1] && c[2]) begin
      for (int i = 0; i < 7; i++) exp_p.push_back({1'b0, nav_b[i]});
    end
    seq = seq + avg;  // advance by averaged count
    drain();
  endtask : scan

  task automatic nav_fix(input logic [1:0] sw);
    logic [23:0] la, lo;
    rnd = lfsr(rnd);
    la = {2'b00, rnd[21:0]};
    rnd = lfsr(rnd);
    lo = {1'b0, rnd[22:0]};
    nav_in <= '{lat: la, lon: lo, south: sw[1], west: sw[0]};
    nav_strobe_in <= 1'b1;
    @(posedge clk_in);
    nav_strobe_in <= 1'b0;
    @(posedge clk_in);
    nav_b = '{la[23:16], la[15:8], la[7:0], lo[23:16], lo[15:8], lo[7:0],
              {sw, 5'h00, 1'b1}};  // flag byte layout
  endtask : nav_fix

  always @(posedge clk_in) begin
    if (scan_valid_in && scan_ready_out === 1'b1) src_q.delete(0);
    scan_valid_in <= (src_q.size() != 0);
    scan_byte_in <= (src_q.size() != 0) ? src_q[0] : ~rnd[7:0];
    if (ser_valid_out === 1'b1 && ser_ready_in) ser_q.push_back(ser_char_out);
    if (par_valid_out === 1'b1 && par_ready_in) begin
      par_q.push_back({par_eoi_out, par_byte_out});
    end
    if (cmd_valid_out === 1'b1) cmd_n++;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    mismatches++;
    test_done();
  end

  initial begin
    rnd = 32'hb75b;
    mismatches = 0;
    checked = 0;
    cmd_n = 0;
    seq = 8'h00;
    avg = 8'h01;
    slow = 1'b0;
    arst_n_in = 1'b0;
    panel_reset_in = 1'b0;
    nv_avg_in = '0;
    nav_strobe_in = 1'b0;
    reg_req_in = '0;
    scan_trail_in = '0;
    nav_in = '0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reg_rd(REG_CTRL);
    check(rd, 32'h0000_0003);  // power-up default
    reg_rd(REG_WORDS);
    check(rd, 32'h0000_000c);  // power-up default
    reg_rd(REG_AVG);
    check(rd, 32'h0000_0001);  // stored count clamped
    reg_rd(8'h20);
    check(rd, 32'h0000_0000);  // unmapped reads as zero
    scan(12, 4'h3);
    reg_wr(REG_AVG, 32'h0000_0003);
    avg = 8'h03;
    reg_wr(REG_WORDS, 32'h0000_0001);
    reg_rd(REG_WORDS);
    check(rd, 32'h0000_0002);  // shortest scan
    slow <= 1'b1;
    scan(2, 4'h3);
    scan(2, 4'h3);
    slow <= 1'b0;
    nav_fix(2'b10);
    reg_wr(REG_CTRL, 32'h0000_0006);
    reg_wr(REG_WORDS, 32'h0000_000c);
    scan(12, 4'h6);
    nav_b[6][0] = 1'b0;
    reg_wr(REG_WORDS, 32'h0000_0002);
    scan(2, 4'h6);
    host.send_line("A5\r\n");
    repeat (4) @(posedge clk_in);
    check({24'h0, cmd_id_out}, 32'h0000_0041);  // id char
    check(cmd_arg_out, 32'h0000_0005);  // argument
    host.send_line("B12\n");
    repeat (4) @(posedge clk_in);
    check({24'h0, cmd_id_out}, 32'h0000_0042);  // no return char
    check(cmd_arg_out, 32'h0000_000c);
    host.send_line("E000000000000000000000000009\n");
    repeat (4) @(posedge clk_in);
    check({24'h0, cmd_id_out}, 32'h0000_0045);  // longest line
    check(cmd_arg_out, 32'h0000_0009);
    host.send_line("D1111111111111111111111111111\nC7\n");
    repeat (4) @(posedge clk_in);
    check(32'(cmd_n), 32'h0000_0004);  // long line dropped
    reg_rd(REG_CMD_ARG);
    check(rd, 32'h0000_0007);
    nav_fix(2'b01);
    reg_wr(REG_CTRL, 32'h0000_0003);
    scan(2, 4'h3);  // new-fix bit kept while no nav block is sent
    reg_wr(REG_CTRL, 32'h0000_0009);
    ser_q.delete();
    for (int i = 0; i < 7; i++) put(nav_b[i], 4'h1, 1'b0);
    exp_s.push_back(CH_CR);
    exp_s.push_back(CH_LF);
    drain();
    reg_wr(REG_CTRL, 32'h0000_0003);
    reg_wr(REG_WORDS, 32'h0000_0005);
    panel_reset_in <= 1'b1;
    @(posedge clk_in);
    panel_reset_in <= 1'b0;
    @(posedge clk_in);
    reg_rd(REG_WORDS);
    check(rd, 32'h0000_000c);  // setting held until panel reset
    reg_rd(REG_AVG);
    check(rd, 32'h0000_0003);  // averaging kept
    test_done();
  end
endmodule : tb
